// *** ppt_params.svh ***
`ifndef PPT_PARAMS_SVH
`define PPT_PARAMS_SVH

// Register indices; byte address is four times the index
`define PPT_IDX_HPEN   10'h09E
`define PPT_IDX_HPDIR  10'h0A0
`define PPT_IDX_PPEN   10'h0A2
`define PPT_IDX_PPDIR  10'h0A4
`define PPT_IDX_VREG   10'h0A6
`define PPT_IDX_BITLEN 10'h0A8
`define PPT_IDX_DCA    10'h0D0
`define PPT_IDX_DCB    10'h0D2
`define PPT_IDX_DRIFT  10'h0DE
`define PPT_IDX_MODE   10'h0E0
`define PPT_IDX_ISTAT  10'h0E2
`define PPT_IDX_ICLR   10'h0E4
`define PPT_IDX_IEN    10'h0E6

// Field widths and positions
`define PPT_PHY_W      4
`define PPT_BITLEN_W   7
`define PPT_VREG_W     2
`define PPT_VREG_PO    0
`define PPT_VREG_LV    1
`define PPT_MODE_CFG   0
`define PPT_IRQ_W      2
`define PPT_IRQ_REJ    0
`define PPT_IRQ_RUN    1

// Reset values
`define PPT_RST_HPEN   16'h0000
`define PPT_RST_HPDIR  16'h0000
`define PPT_RST_PHY    4'h0
`define PPT_RST_PARAM  16'h0000
`define PPT_RST_BITLEN 7'h00
`define PPT_RST_CFG    1'b1
`define PPT_RST_IRQ    2'h0

`endif

// *** ppt_pkg.sv ***
package ppt_pkg;

    // AHB-Lite address phase signals
    typedef struct packed {
        logic        hsel;
        logic [11:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
    } ppt_ahb_req_t;

    // Pull controls for the host interface pin groups
    typedef struct packed {
        logic [15:0] up;
        logic [15:0] down;
    } ppt_host_pull_t;

    // Pull controls for the physical layer pins
    typedef struct packed {
        logic [3:0] up;
        logic [3:0] down;
    } ppt_phy_pull_t;

endpackage : ppt_pkg

// *** ppt_regs.sv ***
// The AHB-Lite interface to the registers was decided locally.
`include "ppt_params.svh"

// What this block does
// - Host direction bit: one pull-up, zero pull-down
// - Host direction register resets to zero
// - Phy enable bits 3..0 gate pulls, reset zero
// - Phy direction bits 3..0 choose pull, reset zero
// - Status bit 1 low-voltage, bit 0 power-on
// - Regulator flags never raise the interrupt
// - Reading status returns it, then clears it
// - Flags set again on each new event
// - Regulator event resets all, flags kept
// - Bit length holds seven bits of microticks
// - Bit length written only in configuration
// - Channel A delay: 16 bits, config-only, 0..127
// - Channel B delay: 16 bits, config-only, 0..127
// - Drift damping: config-only, host keeps 1..15
// - Reset enters configuration; clearing bit leaves
module ppt_regs (
    input  wire logic                    clock_in,
    input  wire logic                    rst_b_in,
    input  wire logic                    clk_en_in,
    input  wire ppt_pkg::ppt_ahb_req_t   ahb_req_in,
    input  wire logic                    hready_in,
    input  wire logic [31:0]             hwdata_in,
    output logic      [31:0]             hrdata_out,
    output logic                         hreadyout_out,
    output logic                         hresp_out,
    input  wire logic                    low_volt_event_in,
    input  wire logic                    power_on_event_in,
    output ppt_pkg::ppt_host_pull_t      host_pull_out,
    output ppt_pkg::ppt_phy_pull_t       phy_pull_out,
    output logic [`PPT_BITLEN_W-1:0]     bit_length_ticks_out,
    output logic [15:0]                  delay_comp_chan_a_out,
    output logic [15:0]                  delay_comp_chan_b_out,
    output logic [15:0]                  drift_damping_out,
    output logic                         config_state_out,
    output logic                         irq_out
);

    // Register storage
    logic [15:0]               host_pin_pull_enable;
    logic [15:0]               host_pin_pull_direction;
    logic [`PPT_PHY_W-1:0]     phy_pin_pull_enable;
    logic [`PPT_PHY_W-1:0]     phy_pin_pull_direction;
    logic [`PPT_VREG_W-1:0]    regulator_reset_status;
    logic [`PPT_BITLEN_W-1:0]  bit_length_ticks;
    logic [15:0]               delay_comp_chan_a;
    logic [15:0]               delay_comp_chan_b;
    logic [15:0]               drift_damping;
    logic                      config_state;
    logic [`PPT_IRQ_W-1:0]     irq_status;
    logic [`PPT_IRQ_W-1:0]     irq_enable;

    // Regulator event synchronisers
    logic [`PPT_VREG_W-1:0]    vreg_raw;
    logic [`PPT_VREG_W-1:0]    vreg_s1;
    logic [`PPT_VREG_W-1:0]    vreg_s2;
    logic [`PPT_VREG_W-1:0]    vreg_s3;
    logic [`PPT_VREG_W-1:0]    vreg_level;
    logic                      reg_hold;
    logic                      soft_rst;

    // Bus pipeline
    logic                      addr_valid;
    logic                      addr_rd;
    logic [9:0]                addr_idx;
    logic                      dp_valid;
    logic                      dp_wr;
    logic [9:0]                dp_idx;
    logic                      wait_q;
    logic                      stall;
    logic                      wr_en;
    logic [15:0]               wdata;
    logic [15:0]               rd_mux;
    logic                      rd_vreg;
    logic                      cfg_wr;
    logic                      cfg_reject;
    logic                      run_event;
    logic [`PPT_IRQ_W-1:0]     irq_events;
    logic [`PPT_IRQ_W-1:0]     irq_clear;

    assign vreg_raw[`PPT_VREG_PO] = power_on_event_in;
    assign vreg_raw[`PPT_VREG_LV] = low_volt_event_in;

    // Three-stage sync per regulator input, accepted when stages agree
    for (genvar i = 0; i < `PPT_VREG_W; i++) begin : g_vsync
        always_ff @(posedge clock_in) begin
            if (!rst_b_in) begin
                vreg_s1[i]    <= 1'b0;
                vreg_s2[i]    <= 1'b0;
                vreg_s3[i]    <= 1'b0;
                vreg_level[i] <= 1'b0;
            end else if (clk_en_in) begin
                vreg_s1[i] <= vreg_raw[i];
                vreg_s2[i] <= vreg_s1[i];
                vreg_s3[i] <= vreg_s2[i];
                if (vreg_s2[i] == vreg_s3[i]) begin
                    vreg_level[i] <= vreg_s3[i];
                end
            end
        end
    end

    // Regulator event acts as soft reset, status flags kept
    assign reg_hold = |vreg_level;
    assign soft_rst = !rst_b_in || reg_hold;

    // Address phase decode; only the word index matters
    assign addr_valid = ahb_req_in.hsel && ahb_req_in.htrans[1] && hready_in;
    assign addr_rd    = addr_valid && !ahb_req_in.hwrite;
    assign addr_idx   = ahb_req_in.haddr[11:2];

    // One wait state when a read follows a write directly
    assign stall         = dp_valid && dp_wr && addr_rd && !wait_q;
    assign hreadyout_out = !stall;
    assign hresp_out     = 1'b0;

    // Data phase tracking
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            dp_valid <= 1'b0;
            dp_wr    <= 1'b0;
            dp_idx   <= 10'h000;
            wait_q   <= 1'b0;
        end else if (clk_en_in) begin
            wait_q <= stall;
            if (hready_in && !stall) begin
                dp_valid <= addr_valid;
                dp_wr    <= ahb_req_in.hwrite;
                dp_idx   <= addr_idx;
            end
        end
    end

    assign wr_en = dp_valid && dp_wr && !reg_hold;
    assign wdata = hwdata_in[15:0];

    assign cfg_wr = wr_en && (dp_idx == `PPT_IDX_BITLEN || dp_idx == `PPT_IDX_DCA
                    || dp_idx == `PPT_IDX_DCB || dp_idx == `PPT_IDX_DRIFT);
    assign cfg_reject = cfg_wr && !config_state;

    // Pin pull registers
    always_ff @(posedge clock_in) begin
        if (soft_rst) begin
            host_pin_pull_enable    <= `PPT_RST_HPEN;
            host_pin_pull_direction <= `PPT_RST_HPDIR;
            phy_pin_pull_enable     <= `PPT_RST_PHY;
            phy_pin_pull_direction  <= `PPT_RST_PHY;
        end else if (clk_en_in && wr_en) begin
            if (dp_idx == `PPT_IDX_HPEN) begin
                host_pin_pull_enable <= wdata;
            end
            if (dp_idx == `PPT_IDX_HPDIR) begin
                host_pin_pull_direction <= wdata;
            end
            if (dp_idx == `PPT_IDX_PPEN) begin
                phy_pin_pull_enable <= wdata[`PPT_PHY_W-1:0];
            end
            if (dp_idx == `PPT_IDX_PPDIR) begin
                phy_pin_pull_direction <= wdata[`PPT_PHY_W-1:0];
            end
        end
    end

    // Timing parameters, writable only in configuration state
    always_ff @(posedge clock_in) begin
        if (soft_rst) begin
            bit_length_ticks  <= `PPT_RST_BITLEN;
            delay_comp_chan_a <= `PPT_RST_PARAM;
            delay_comp_chan_b <= `PPT_RST_PARAM;
            drift_damping     <= `PPT_RST_PARAM;
        end else if (clk_en_in && cfg_wr && config_state) begin
            if (dp_idx == `PPT_IDX_BITLEN) begin
                bit_length_ticks <= wdata[`PPT_BITLEN_W-1:0];
            end
            if (dp_idx == `PPT_IDX_DCA) begin
                delay_comp_chan_a <= wdata;
            end
            if (dp_idx == `PPT_IDX_DCB) begin
                delay_comp_chan_b <= wdata;
            end
            if (dp_idx == `PPT_IDX_DRIFT) begin
                drift_damping <= wdata;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (soft_rst) begin
            config_state <= `PPT_RST_CFG;
        end else if (clk_en_in && wr_en && dp_idx == `PPT_IDX_MODE) begin
            config_state <= wdata[`PPT_MODE_CFG];
        end
    end

    assign run_event = wr_en && dp_idx == `PPT_IDX_MODE
                       && config_state && !wdata[`PPT_MODE_CFG];

    // Clear on read, taken in the address phase
    assign rd_vreg = addr_rd && !stall && addr_idx == `PPT_IDX_VREG;

    // Set wins over the read clear
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            regulator_reset_status <= '0;
        end else if (clk_en_in) begin
            regulator_reset_status <= (rd_vreg ? '0 : regulator_reset_status)
                                      | vreg_level;
        end
    end

    // Interrupt sources and software clear
    assign irq_events[`PPT_IRQ_REJ] = cfg_reject;
    assign irq_events[`PPT_IRQ_RUN] = run_event;
    assign irq_clear = (wr_en && dp_idx == `PPT_IDX_ICLR)
                       ? wdata[`PPT_IRQ_W-1:0] : '0;

    // Sticky interrupt status, set beats clear
    always_ff @(posedge clock_in) begin
        if (soft_rst) begin
            irq_status <= `PPT_RST_IRQ;
        end else if (clk_en_in) begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    // Interrupt enable register
    always_ff @(posedge clock_in) begin
        if (soft_rst) begin
            irq_enable <= `PPT_RST_IRQ;
        end else if (clk_en_in && wr_en && dp_idx == `PPT_IDX_IEN) begin
            irq_enable <= wdata[`PPT_IRQ_W-1:0];
        end
    end

    // Regulator flags kept out of the interrupt
    assign irq_out = |(irq_status & irq_enable);

    // Read mux, reserved and unmapped bits zero
    always_comb begin
        rd_mux = 16'h0000;
        unique case (addr_idx)
            `PPT_IDX_HPEN:   rd_mux = host_pin_pull_enable;
            `PPT_IDX_HPDIR:  rd_mux = host_pin_pull_direction;
            `PPT_IDX_PPEN:   rd_mux[`PPT_PHY_W-1:0] = phy_pin_pull_enable;
            `PPT_IDX_PPDIR:  rd_mux[`PPT_PHY_W-1:0] = phy_pin_pull_direction;
            `PPT_IDX_VREG:   rd_mux[`PPT_VREG_W-1:0] = regulator_reset_status;
            `PPT_IDX_BITLEN: rd_mux[`PPT_BITLEN_W-1:0] = bit_length_ticks;
            `PPT_IDX_DCA:    rd_mux = delay_comp_chan_a;
            `PPT_IDX_DCB:    rd_mux = delay_comp_chan_b;
            `PPT_IDX_DRIFT:  rd_mux = drift_damping;
            `PPT_IDX_MODE:   rd_mux[`PPT_MODE_CFG] = config_state;
            `PPT_IDX_ISTAT:  rd_mux[`PPT_IRQ_W-1:0] = irq_status;
            `PPT_IDX_IEN:    rd_mux[`PPT_IRQ_W-1:0] = irq_enable;
            default:         rd_mux = 16'h0000;
        endcase
    end

    // Read data captured at the address phase
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (clk_en_in && addr_rd && !stall) begin
            hrdata_out <= {16'h0000, rd_mux};
        end
    end

    assign host_pull_out.up   = host_pin_pull_enable & host_pin_pull_direction;
    assign host_pull_out.down = host_pin_pull_enable & ~host_pin_pull_direction;
    assign phy_pull_out.up    = phy_pin_pull_enable & phy_pin_pull_direction;
    assign phy_pull_out.down  = phy_pin_pull_enable & ~phy_pin_pull_direction;

    // Parameter outputs
    assign bit_length_ticks_out  = bit_length_ticks;
    assign delay_comp_chan_a_out = delay_comp_chan_a;
    assign delay_comp_chan_b_out = delay_comp_chan_b;
    assign drift_damping_out     = drift_damping;
    assign config_state_out      = config_state;

    // Checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    host_pull_map_a: assert property (
        (host_pull_out.up | host_pull_out.down) == host_pin_pull_enable
        && (host_pull_out.up & host_pull_out.down) == 16'h0000)
        else $error("host pull outputs disagree with enable");

    host_dir_rst_a: assert property (
        $past(!rst_b_in) |-> host_pin_pull_direction == 16'h0000)
        else $error("host pull direction not zero after reset");

    phy_en_map_a: assert property (
        $past(!rst_b_in) |-> phy_pull_out.up == 4'h0 && phy_pull_out.down == 4'h0)
        else $error("phy pulls active after reset");

    phy_dir_map_a: assert property (
        phy_pull_out.up == (phy_pin_pull_enable & phy_pin_pull_direction))
        else $error("phy pull-up does not follow direction");

    vreg_set_a: assert property (
        clk_en_in && vreg_level[`PPT_VREG_LV]
        |=> regulator_reset_status[`PPT_VREG_LV])
        else $error("low-voltage flag not set");

    po_flag_set_a: assert property (
        clk_en_in && vreg_level[`PPT_VREG_PO]
        |=> regulator_reset_status[`PPT_VREG_PO])
        else $error("power-on flag not set");

    flags_sticky_a: assert property (
        clk_en_in && !rd_vreg |=> (regulator_reset_status & $past(regulator_reset_status))
        == $past(regulator_reset_status))
        else $error("regulator flag lost without a read");

    vreg_no_irq_a: assert property (
        vreg_level != 2'h0 |=> !irq_out)
        else $error("regulator event raised the interrupt");

    vreg_rd_clr_a: assert property (
        clk_en_in && rd_vreg && vreg_level == 2'h0
        |=> regulator_reset_status == 2'h0
        && hrdata_out[1:0] == $past(regulator_reset_status))
        else $error("status read did not return and clear");

    vreg_reset_a: assert property (
        clk_en_in && reg_hold |=> config_state && host_pin_pull_enable == 16'h0000
        && regulator_reset_status != 2'h0)
        else $error("regulator event did not reset the bank");

    param_lock_a: assert property (
        !config_state && !reg_hold ##1 rst_b_in
        |-> $stable(bit_length_ticks) && $stable(delay_comp_chan_a)
        && $stable(delay_comp_chan_b) && $stable(drift_damping))
        else $error("parameter changed outside configuration");

    cfg_entry_a: assert property (
        $past(!rst_b_in) |-> config_state_out)
        else $error("not in configuration after reset");

    resv_zero_a: assert property (
        hrdata_out[31:16] == 16'h0000)
        else $error("reserved read bits not zero");

    // Low clock enable outside soft reset holds config state, irq status, host direction and regulator flags
    freeze_hold_a: assert property (
        !clk_en_in && !soft_rst |=> $stable(config_state) && $stable(irq_status)
        && $stable(host_pin_pull_direction) && $stable(regulator_reset_status))
        else $error("state moved while clock enable low");

    vreg_read_c: cover property (rd_vreg && regulator_reset_status != 2'h0);
    reject_wr_c: cover property (cfg_reject);
    irq_fire_c:  cover property (irq_out ##1 !irq_out);
    cfg_leave_c: cover property (run_event);
    vreg_hold_c: cover property (reg_hold ##1 !reg_hold);

endmodule : ppt_regs

// *** ppt_regs_tb.sv ***
`include "ppt_params.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] a_hpen  = {`PPT_IDX_HPEN, 2'b00};
    localparam logic [11:0] a_hpdir = {`PPT_IDX_HPDIR, 2'b00};
    localparam logic [11:0] a_ppen  = {`PPT_IDX_PPEN, 2'b00};
    localparam logic [11:0] a_ppdir = {`PPT_IDX_PPDIR, 2'b00};
    localparam logic [11:0] a_vreg  = {`PPT_IDX_VREG, 2'b00};
    localparam logic [11:0] a_bitl  = {`PPT_IDX_BITLEN, 2'b00};
    localparam logic [11:0] a_dca   = {`PPT_IDX_DCA, 2'b00};
    localparam logic [11:0] a_dcb   = {`PPT_IDX_DCB, 2'b00};
    localparam logic [11:0] a_drift = {`PPT_IDX_DRIFT, 2'b00};
    localparam logic [11:0] a_mode  = {`PPT_IDX_MODE, 2'b00};
    localparam logic [11:0] a_istat = {`PPT_IDX_ISTAT, 2'b00};
    localparam logic [11:0] a_iclr  = {`PPT_IDX_ICLR, 2'b00};
    localparam logic [11:0] a_ien   = {`PPT_IDX_IEN, 2'b00};

    logic                    clock_in = 1'b0;
    logic                    rst_b_in;
    logic                    clk_en;
    ppt_pkg::ppt_ahb_req_t   req;
    logic [31:0]             hwdata;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic                    hresp;
    logic                    lv;
    logic                    po;
    ppt_pkg::ppt_host_pull_t host_pull;
    ppt_pkg::ppt_phy_pull_t  phy_pull;
    logic [6:0]              bitl;
    logic [15:0]             dca;
    logic [15:0]             dcb;
    logic [15:0]             drift;
    logic                    cfg;
    logic                    irq;
    logic                    rd_phase;
    logic [31:0]             exp_q[$];
    logic [31:0]             exp_v;
    logic [15:0]             en, dir, pe, pd, bl, da, db, dd;
    int                      n_fail;
    int                      n_compared;
    int                      junk;

    ppt_regs ppt_regs_inst (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en), .ahb_req_in(req),
        .hready_in(hreadyout), .hwdata_in(hwdata), .hrdata_out(hrdata),
        .hreadyout_out(hreadyout), .hresp_out(hresp), .low_volt_event_in(lv),
        .power_on_event_in(po), .host_pull_out(host_pull), .phy_pull_out(phy_pull),
        .bit_length_ticks_out(bitl), .delay_comp_chan_a_out(dca),
        .delay_comp_chan_b_out(dcb), .drift_damping_out(drift),
        .config_state_out(cfg), .irq_out(irq)
    );

    // Free running clock, 8 ns period
    always #4 clock_in = ~clock_in;

    task automatic close_out;
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask : cmp

    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready;
        int k;
        k = 0;
        @(posedge clock_in);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                $display("BAD hready_wait expected 1 seen %b", hreadyout);
                n_fail++;
                close_out;
            end
            @(posedge clock_in);
        end
    endtask : wait_ready

    task automatic bus_write(input logic [11:0] a, input logic [15:0] d);
        req <= '{hsel: 1'b1, haddr: a, htrans: 2'b10, hwrite: 1'b1, hsize: 3'b010};
        wait_ready;
        req <= '{hsel: 1'b0, haddr: a, htrans: 2'b00, hwrite: 1'b0, hsize: 3'b010};
        hwdata <= {16'($urandom_range(16'hFFFF)), d};
        wait_ready;
        hwdata <= $urandom;
    endtask : bus_write

    // Read; expectation noted for the watching process
    task automatic bus_read(input logic [11:0] a, input logic [15:0] e);
        req <= '{hsel: 1'b1, haddr: a, htrans: 2'b10, hwrite: 1'b0, hsize: 3'b010};
        wait_ready;
        req <= '{hsel: 1'b0, haddr: a, htrans: 2'b00, hwrite: 1'b0, hsize: 3'b010};
        rd_phase <= 1'b1;
        exp_q.push_back({16'h0000, e});
        wait_ready;
        rd_phase <= 1'b0;
    endtask : bus_read

    // Compares read data at the edge ending each data phase
    always @(posedge clock_in) begin
        if (rd_phase === 1'b1 && hreadyout === 1'b1) begin
            exp_v = exp_q.pop_front();
            cmp("hrdata_out", exp_v, hrdata);
            cmp("hresp_out", 32'h0, {31'h0, hresp});
        end
    end

    // Writes four parameters, reads back and checks the outputs
    task automatic par_rw(input logic [15:0] b, a, c, d, eb, ea, ec, ed);
        bus_write(a_bitl, b);
        bus_write(a_dca, a);
        bus_write(a_dcb, c);
        bus_write(a_drift, d);
        bus_read(a_bitl, eb & 16'h007F);
        bus_read(a_dca, ea);
        bus_read(a_dcb, ec);
        bus_read(a_drift, ed);
        @(negedge clock_in);
        cmp("bit_length_ticks_out", {25'h0, eb[6:0]}, {25'h0, bitl});
        cmp("delay_comp_chan_a_out", {16'h0, ea}, {16'h0, dca});
        cmp("delay_comp_chan_b_out", {16'h0, ec}, {16'h0, dcb});
        cmp("drift_damping_out", {16'h0, ed}, {16'h0, drift});
        @(posedge clock_in);
    endtask : par_rw

    task automatic port_bit(input string nm, input logic e, ref logic s);
        @(negedge clock_in);
        cmp(nm, {31'h0, e}, {31'h0, s});
        @(posedge clock_in);
    endtask : port_bit

    initial begin
        req = '0;
        hwdata = 32'h0000_0000;
        rst_b_in = 1'b0;
        clk_en = 1'b1;
        lv = 1'b0;
        po = 1'b0;
        rd_phase = 1'b0;
        n_fail = 0;
        n_compared = 0;
        junk = $urandom(32'h1db6);
        repeat (5) @(posedge clock_in);
        rst_b_in <= 1'b1;
        @(posedge clock_in);
        // Reset values
        bus_read(a_hpdir, 16'h0000);
        bus_read(a_ppen, 16'h0000);
        bus_read(a_ppdir, 16'h0000);
        bus_read(a_mode, 16'h0001);
        port_bit("config_state_out", 1'b1, cfg);
        // Pull enables and directions with random patterns
        for (int i = 0; i < 4; i++) begin
            en = 16'($urandom);
            dir = 16'($urandom);
            pe = 16'($urandom);
            pd = 16'($urandom);
            bus_write(a_hpen, en);
            bus_write(a_hpdir, dir);
            bus_write(a_ppen, pe);
            bus_write(a_ppdir, pd);
            bus_read(a_hpdir, dir);
            bus_read(a_ppen, {12'h000, pe[3:0]});
            bus_read(a_ppdir, {12'h000, pd[3:0]});
            @(negedge clock_in);
            cmp("host_pull_up", {16'h0, en & dir}, {16'h0, host_pull.up});
            cmp("host_pull_down", {16'h0, en & ~dir}, {16'h0, host_pull.down});
            cmp("phy_pull_up", {28'h0, pe[3:0] & pd[3:0]}, {28'h0, phy_pull.up});
            cmp("phy_pull_down", {28'h0, pe[3:0] & ~pd[3:0]}, {28'h0, phy_pull.down});
            @(posedge clock_in);
        end
        // Unmapped place reads zero
        bus_write(12'h004, 16'hFFFF);
        bus_read(12'h004, 16'h0000);
        // Parameters in configuration, then refused outside it
        bl = 16'($urandom);
        da = 16'($urandom_range(127));
        db = 16'($urandom_range(127));
        dd = 16'($urandom_range(15, 1));
        par_rw(bl, da, db, dd, bl, da, db, dd);
        bus_write(a_ien, 16'h0003);
        bus_write(a_mode, 16'h0000);
        port_bit("config_state_out", 1'b0, cfg);
        bus_read(a_istat, 16'h0002);
        bus_write(a_iclr, 16'h0002);
        port_bit("irq_out", 1'b0, irq);
        par_rw(~bl, 16'((da + 1) % 128), 16'((db + 1) % 128), 16'(dd % 15 + 1),
               bl, da, db, dd);
        port_bit("irq_out", 1'b1, irq);
        bus_write(a_ien, 16'h0000);
        port_bit("irq_out", 1'b0, irq);
        bus_read(a_istat, 16'h0001);
        bus_write(a_iclr, 16'h0001);
        bus_read(a_istat, 16'h0000);
        bus_write(a_mode, 16'h0001);
        par_rw(~bl, 16'((da + 1) % 128), 16'((db + 1) % 128), 16'(dd % 15 + 1),
               ~bl, 16'((da + 1) % 128), 16'((db + 1) % 128), 16'(dd % 15 + 1));
        // Frozen block ignores a regulator pulse
        bus_write(a_hpdir, 16'h5A5A);
        clk_en <= 1'b0;
        lv <= 1'b1;
        repeat (10) @(posedge clock_in);
        clk_en <= 1'b1;
        lv <= 1'b0;
        repeat (10) @(posedge clock_in);
        bus_read(a_vreg, 16'h0000);
        bus_read(a_hpdir, 16'h5A5A);
        // Regulator events: each code, read-clear, reset effects
        for (int c = 1; c < 4; c++) begin
            bus_write(a_hpdir, 16'hA5A5);
            bus_write(a_ien, 16'h0003);
            lv <= c[1];
            po <= c[0];
            repeat (10) @(posedge clock_in);
            lv <= 1'b0;
            po <= 1'b0;
            repeat (10) @(posedge clock_in);
            bus_read(a_vreg, c[15:0]);
            bus_read(a_vreg, 16'h0000);
            bus_read(a_hpdir, 16'h0000);
            bus_read(a_ien, 16'h0000);
            bus_read(a_mode, 16'h0001);
            port_bit("irq_out", 1'b0, irq);
        end
        repeat (3) @(posedge clock_in);
        close_out;
    end
endmodule : testbench
